// ==== src/txf_pkg.sv ====
// constants for the transmit queue chain and dma request block
package txf_pkg;
    localparam logic [11:0] OFS_CTRL     = 12'h000;
    localparam logic [11:0] OFS_FILL     = 12'h004;
    localparam logic [11:0] OFS_DESC     = 12'h008;
    localparam logic [11:0] OFS_LOAD     = 12'h00C;
    localparam logic [11:0] OFS_IRQ      = 12'h010;
    localparam logic [11:0] OFS_DATA     = 12'h014;
    localparam logic [11:0] OFS_DIAG     = 12'h018;
    localparam int          CTRL_DMA_EN  = 0;
    localparam int          CTRL_IRQ_EN  = 1;
    localparam int          CTRL_START   = 2;
    localparam int          DESC_LAST    = 0;
    localparam logic [23:0] FILL_RST     = 24'h000400;
    localparam int          ING_DEPTH    = 32;
    localparam int          BRST_DEPTH   = 256;
    localparam int          SMTH_DEPTH   = 128;
    localparam int          SD_WORDS     = 2097152;
    localparam logic [23:0] SD_BYTES     = 24'h800000;
    localparam logic [23:0] CEIL_EXTRA   = 24'h000100;
    localparam logic [8:0]  BRST_LOW_W   = 9'h010;
    localparam logic [8:0]  BRST_HIGH_W  = 9'h080;
    localparam logic [5:0]  SD_BURST_MAX = 6'h20;
    localparam logic [5:0]  MAX_OUTST    = 6'h08;
    localparam logic [1:0]  DESC_WORDS   = 2'h3;
endpackage : txf_pkg

// ==== src/txf_top.sv ====
// transmit queue chain with occupancy counter, dma request control and descriptor walker
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps

module txf_queue #(
    parameter int W  = 32,
    parameter int D  = 32,
    parameter int AW = 5
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          wr_en,
    input  wire logic [W-1:0]  wr_data,
    input  wire logic          rd_en,
    output logic      [W-1:0]  rd_data,
    output logic               empty,
    output logic      [AW:0]   count
);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;

    assign rd_data = mem[rptr];
    assign empty   = (count == '0);

    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wptr] <= wr_data;
        end
    end

    // wrapping pointers; the writer never checks full, its feeder must
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end
        else
        begin
            wptr  <= wptr + AW'(wr_en);
            rptr  <= rptr + AW'(rd_en);
            count <= count + (AW+1)'(wr_en) - (AW+1)'(rd_en);
        end
    end
endmodule : txf_queue

module txf_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             mem_req,
    output logic      [31:0] mem_addr,
    input  wire logic        mem_gnt,
    input  wire logic        mem_rvalid,
    input  wire logic [31:0] mem_rdata,
    output logic             dma_req,
    output logic             chain_irq,
    output logic             sd_req,
    output logic             sd_we,
    output logic      [20:0] sd_addr,
    output logic      [31:0] sd_wdata,
    input  wire logic        sd_rvalid,
    input  wire logic [31:0] sd_rdata,
    output logic             out_valid,
    output logic      [7:0]  out_data,
    input  wire logic        out_ready
);
    import txf_pkg::*;

    typedef enum logic [2:0] {ENG_IDLE, ENG_FETCH, ENG_WAIT, ENG_MOVE} txf_eng_t;
    typedef enum logic [1:0] {BK_IDLE, BK_WR, BK_RD} txf_bulk_t;

    logic        dma_en;
    logic        irq_en;
    logic [23:0] fill_limit;
    logic [31:0] desc_ptr;
    logic        chain_done;
    logic [23:0] occ;
    logic        burst_win;
    txf_eng_t    eng;
    logic [1:0]  desc_idx;
    logic [31:0] buf_addr;
    logic [23:0] remaining;
    logic        desc_last;
    logic [5:0]  outst;
    txf_bulk_t   bulk;
    logic        prefer_rd;
    logic [5:0]  bcnt;
    logic [21:0] sd_level;
    logic [20:0] sd_wptr;
    logic [20:0] sd_rptr;
    logic [7:0]  rd_infl;
    logic        xfer_valid;
    logic [31:0] xfer_data;
    logic        sm_in_valid;
    logic [31:0] sm_in_data;
    logic [1:0]  byte_idx;

    logic        ing_empty, brst_empty, sm_empty;
    logic [5:0]  ing_count;
    logic [8:0]  brst_count;
    logic [7:0]  sm_count;
    logic [31:0] ing_rdata, brst_rdata, sm_rdata;

    logic        apb_wr, apb_setup, data_wr, ceiling, ing_wr, move_data;
    logic        next_mem_req, can_wr, can_rd, wr_go, rd_go, out_take, sm_pop, load_byte;
    logic [31:0] ing_wdata;

    assign apb_setup = psel && !penable;
    assign pready    = !(paddr == OFS_DATA && pwrite && eng == ENG_MOVE);
    assign apb_wr    = psel && penable && pwrite && pready;
    assign data_wr   = apb_wr && paddr == OFS_DATA;
    assign move_data = (eng == ENG_MOVE) && mem_rvalid;
    assign ceiling   = occ >= (SD_BYTES + CEIL_EXTRA);
    assign ing_wr    = !ceiling && (move_data || data_wr);
    assign ing_wdata = move_data ? mem_rdata : pwdata;
    assign chain_irq = chain_done && irq_en;

    assign dma_req   = dma_en && (occ < fill_limit) && burst_win;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end
        else if (apb_setup)
        begin
            pslverr <= 1'b0;
            if (paddr == OFS_CTRL)
                prdata <= {30'h0, irq_en, dma_en};
            else if (paddr == OFS_FILL)
                prdata <= {8'h0, fill_limit};
            else if (paddr == OFS_DESC)
                prdata <= desc_ptr;
            else if (paddr == OFS_LOAD)
                prdata <= {8'h0, occ};
            else if (paddr == OFS_IRQ)
                prdata <= {31'h0, chain_done};
            else if (paddr == OFS_DATA)
                prdata <= 32'h0;
            else if (paddr == OFS_DIAG)
                prdata <= {19'h0, eng != ENG_IDLE, dma_req, 2'h0, brst_count};
            else
            begin
                prdata  <= 32'h0;
                pslverr <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dma_en     <= 1'b0;
            irq_en     <= 1'b0;
            fill_limit <= FILL_RST;
        end
        else if (apb_wr && paddr == OFS_CTRL)
        begin
            dma_en <= pwdata[CTRL_DMA_EN];
            irq_en <= pwdata[CTRL_IRQ_EN];
        end
        else if (apb_wr && paddr == OFS_FILL)
        begin
            fill_limit <= pwdata[23:0];
        end
    end

    // set wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            chain_done <= 1'b0;
        else if (eng == ENG_MOVE && remaining == 24'h0 && outst == 6'h0 && desc_last)
            chain_done <= 1'b1;
        else if (apb_wr && paddr == OFS_IRQ && pwdata[0])
            chain_done <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            occ <= 24'h0;
        else
            occ <= occ + (ing_wr ? 24'h4 : 24'h0) - (out_take ? 24'h1 : 24'h0);
    end

    // hysteresis so bursts stay long; 128 words plus ingress never overruns 256
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            burst_win <= 1'b1;
        else if (brst_count < BRST_LOW_W)
            burst_win <= 1'b1;
        else if (brst_count >= BRST_HIGH_W)
            burst_win <= 1'b0;
    end

    always_comb
    begin
        next_mem_req = 1'b0;
        mem_addr     = buf_addr;
        if (eng == ENG_FETCH)
        begin
            next_mem_req = 1'b1;
            mem_addr     = desc_ptr + {28'h0, desc_idx, 2'b00};
        end
        else if (eng == ENG_MOVE)
        begin
            next_mem_req = dma_req && remaining != 24'h0 && outst < MAX_OUTST;
        end
    end
    assign mem_req = next_mem_req;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            eng       <= ENG_IDLE;
            desc_idx  <= 2'h0;
            desc_ptr  <= 32'h0;
            buf_addr  <= 32'h0;
            remaining <= 24'h0;
            desc_last <= 1'b0;
            outst     <= 6'h0;
        end
        else
        begin
            case (eng)
                ENG_IDLE:
                begin
                    if (apb_wr && paddr == OFS_DESC)
                        desc_ptr <= pwdata;
                    if (apb_wr && paddr == OFS_CTRL && pwdata[CTRL_START])
                    begin
                        desc_idx <= 2'h0;
                        eng      <= ENG_FETCH;
                    end
                end
                ENG_FETCH:
                begin
                    if (mem_gnt)
                        eng <= ENG_WAIT;
                end
                ENG_WAIT:
                begin
                    if (mem_rvalid)
                    begin
                        if (desc_idx == 2'h0)
                            buf_addr <= mem_rdata;
                        else if (desc_idx == 2'h1)
                            remaining <= mem_rdata[23:0];
                        else
                        begin
                            desc_last <= mem_rdata[DESC_LAST];
                            desc_ptr  <= {mem_rdata[31:2], 2'b00};
                        end
                        desc_idx <= desc_idx + 2'h1;
                        eng      <= (desc_idx == DESC_WORDS - 2'h1) ? ENG_MOVE : ENG_FETCH;
                    end
                end
                ENG_MOVE:
                begin
                    outst <= outst + 6'(next_mem_req && mem_gnt) - 6'(mem_rvalid);
                    if (next_mem_req && mem_gnt)
                    begin
                        buf_addr  <= buf_addr + 32'h4;
                        remaining <= (remaining > 24'h4) ? remaining - 24'h4 : 24'h0;
                    end
                    if (remaining == 24'h0 && outst == 6'h0)
                    begin
                        desc_idx <= 2'h0;
                        eng      <= desc_last ? ENG_IDLE : ENG_FETCH;
                    end
                end
                default:
                    eng <= ENG_IDLE;
            endcase
        end
    end

    txf_queue #(.W(32), .D(ING_DEPTH), .AW(5)) u_ing (
        .clk     (pclk),
        .rstn    (presetn),
        .wr_en   (ing_wr),
        .wr_data (ing_wdata),
        .rd_en   (!ing_empty),
        .rd_data (ing_rdata),
        .empty   (ing_empty),
        .count   (ing_count)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            xfer_valid <= 1'b0;
            xfer_data  <= 32'h0;
        end
        else
        begin
            xfer_valid <= !ing_empty;
            xfer_data  <= ing_rdata;
        end
    end

    txf_queue #(.W(32), .D(BRST_DEPTH), .AW(8)) u_brst (
        .clk     (pclk),
        .rstn    (presetn),
        .wr_en   (xfer_valid),
        .wr_data (xfer_data),
        .rd_en   (wr_go),
        .rd_data (brst_rdata),
        .empty   (brst_empty),
        .count   (brst_count)
    );

    assign can_wr = !brst_empty && sd_level < 22'(SD_WORDS);
    assign can_rd = sd_level != 22'h0 && ({1'b0, sm_count} + {1'b0, rd_infl}) < 9'(SMTH_DEPTH - 2);
    assign wr_go  = bulk == BK_WR && can_wr && bcnt < SD_BURST_MAX;
    assign rd_go  = bulk == BK_RD && can_rd && bcnt < SD_BURST_MAX;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bulk      <= BK_IDLE;
            bcnt      <= 6'h0;
            prefer_rd <= 1'b0;
        end
        else
        begin
            case (bulk)
                BK_IDLE:
                begin
                    bcnt <= 6'h0;
                    if (can_rd && (prefer_rd || !can_wr))
                        bulk <= BK_RD;
                    else if (can_wr)
                        bulk <= BK_WR;
                end
                BK_WR:
                begin
                    bcnt <= bcnt + 6'(wr_go);
                    if (!wr_go)
                    begin
                        bulk      <= BK_IDLE;
                        prefer_rd <= 1'b1;
                    end
                end
                BK_RD:
                begin
                    bcnt <= bcnt + 6'(rd_go);
                    if (!rd_go)
                    begin
                        bulk      <= BK_IDLE;
                        prefer_rd <= 1'b0;
                    end
                end
                default:
                    bulk <= BK_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sd_req   <= 1'b0;
            sd_we    <= 1'b0;
            sd_addr  <= 21'h0;
            sd_wdata <= 32'h0;
            sd_wptr  <= 21'h0;
            sd_rptr  <= 21'h0;
            sd_level <= 22'h0;
        end
        else
        begin
            sd_req   <= wr_go || rd_go;
            sd_we    <= wr_go;
            sd_addr  <= wr_go ? sd_wptr : sd_rptr;
            sd_wdata <= brst_rdata;
            sd_wptr  <= sd_wptr + 21'(wr_go);
            sd_rptr  <= sd_rptr + 21'(rd_go);
            sd_level <= sd_level + 22'(wr_go) - 22'(rd_go);
        end
    end

    // in-flight reads reserve smoothing room so returns never overflow it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sm_in_valid <= 1'b0;
            sm_in_data  <= 32'h0;
            rd_infl     <= 8'h0;
        end
        else
        begin
            sm_in_valid <= sd_rvalid;
            sm_in_data  <= sd_rdata;
            rd_infl     <= rd_infl + 8'(rd_go) - 8'(sm_in_valid);
        end
    end

    txf_queue #(.W(32), .D(SMTH_DEPTH), .AW(7)) u_smth (
        .clk     (pclk),
        .rstn    (presetn),
        .wr_en   (sm_in_valid),
        .wr_data (sm_in_data),
        .rd_en   (sm_pop),
        .rd_data (sm_rdata),
        .empty   (sm_empty),
        .count   (sm_count)
    );

    assign out_take  = out_valid && out_ready;
    assign load_byte = !sm_empty && (!out_valid || out_ready);
    assign sm_pop    = load_byte && byte_idx == 2'h3;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_valid <= 1'b0;
            out_data  <= 8'h0;
            byte_idx  <= 2'h0;
        end
        else if (load_byte)
        begin
            out_valid <= 1'b1;
            out_data  <= sm_rdata[8*byte_idx +: 8];
            byte_idx  <= byte_idx + 2'h1;
        end
        else if (out_take)
        begin
            out_valid <= 1'b0;
        end
    end
endmodule : txf_top

// ==== tb/txf_props.sv ====
// assertion checker for the transmit queue block
`timescale 1ns/1ps
module txf_props
    import txf_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        mem_req,
    input wire logic        mem_rvalid,
    input wire logic        dma_req,
    input wire logic        chain_irq,
    input wire logic        sd_req,
    input wire logic        sd_we,
    input wire logic [20:0] sd_addr,
    input wire logic        out_valid,
    input wire logic [7:0]  out_data,
    input wire logic        out_ready
);
    logic [6:0]  run;
    logic [3:0]  since_rv;
    logic [20:0] last_wa;
    logic        have_wa;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run <= 7'h00;
        else
            run <= sd_req ? run + 7'h01 : 7'h00;
    end
    // saturating count of cycles since the last host read return
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            since_rv <= 4'hF;
        else if (mem_rvalid)
            since_rv <= 4'h0;
        else if (since_rv != 4'hF)
            since_rv <= since_rv + 4'h1;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            have_wa <= 1'b0;
        else if (sd_req && sd_we)
            have_wa <= 1'b1;
    end
    always_ff @(posedge pclk)
    begin
        if (sd_req && sd_we)
            last_wa <= sd_addr;
    end
    sequence s_acc_stall;
        psel && penable && !pready;
    endsequence
    sequence s_out_stall;
        out_valid && !out_ready;
    endsequence
    a_reset_quiet: assert property ($rose(presetn) |-> !dma_req && !mem_req && !out_valid)
        else $error("request or output raised right after reset");
    a_pready_cause: assert property (s_acc_stall |-> pwrite && paddr == OFS_DATA)
        else $error("wait state on an access other than a stream word write");
    a_map_error: assert property (psel && penable && paddr[1:0] == 2'h0 |-> pslverr == (paddr > OFS_DIAG))
        else $error("error response does not match the address map");
    a_irq_cause: assert property ($rose(chain_irq) |-> since_rv < 4'h8 || $past(psel) && $past(pwrite))
        else $error("chain interrupt rose without a completed host read");
    a_out_hold: assert property (s_out_stall |=> out_valid && $stable(out_data))
        else $error("output byte changed while stalled");
    a_sd_nomix: assert property (sd_req && $past(sd_req) |-> sd_we == $past(sd_we))
        else $error("sdram direction changed inside a burst");
    a_sd_burst: assert property (sd_req |-> run < 7'h20)
        else $error("sdram burst longer than the limit");
    a_sd_wseq: assert property (sd_req && sd_we && have_wa |-> sd_addr == last_wa + 21'h1)
        else $error("sdram write address not sequential");
endmodule : txf_props
bind txf_top txf_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
    .mem_rvalid(mem_rvalid), .dma_req(dma_req), .chain_irq(chain_irq), .sd_req(sd_req), .sd_we(sd_we),
    .sd_addr(sd_addr), .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));

// ==== tb/txf_far_model.sv ====
// far side model: host memory, sdram and output sink
`timescale 1ns/1ps
module txf_far_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        slow,
    input  wire logic        sink_go,
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    output logic             mem_gnt,
    output logic             mem_rvalid,
    output logic      [31:0] mem_rdata,
    input  wire logic        sd_req,
    input  wire logic        sd_we,
    input  wire logic [20:0] sd_addr,
    input  wire logic [31:0] sd_wdata,
    output logic             sd_rvalid,
    output logic      [31:0] sd_rdata,
    input  wire logic        out_valid,
    input  wire logic [7:0]  out_data,
    output logic             out_ready
);
    logic [31:0] hmem [0:63];
    logic [31:0] sdm [int];
    logic [31:0] mq [$];
    logic [31:0] sq [$];
    int          mt [$];
    int          st [$];
    int          cyc;
    logic [7:0]  got [$];
    // slow mode grants every other cycle and answers late
    assign mem_gnt = mem_req && (!slow || cyc[0]);
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cyc <= 0;
            mem_rvalid <= 1'b0;
            mem_rdata <= 32'h0;
            sd_rvalid <= 1'b0;
            sd_rdata <= 32'h0;
            out_ready <= 1'b0;
            mq.delete();
            mt.delete();
            sq.delete();
            st.delete();
        end
        else
        begin
            cyc <= cyc + 1;
            mem_rvalid <= mt.size() > 0 && mt[0] <= cyc;
            if (mt.size() > 0 && mt[0] <= cyc)
            begin
                mem_rdata <= mq.pop_front();
                void'(mt.pop_front());
            end
            else
                mem_rdata <= ~mem_rdata;
            if (mem_req && mem_gnt)
            begin
                mq.push_back(hmem[mem_addr[7:2]]);
                mt.push_back(cyc + (slow ? 3 : 1));
            end
            sd_rvalid <= st.size() > 0 && st[0] <= cyc;
            if (st.size() > 0 && st[0] <= cyc)
            begin
                sd_rdata <= sq.pop_front();
                void'(st.pop_front());
            end
            else
                sd_rdata <= ~sd_rdata;
            if (sd_req && sd_we)
                sdm[int'(sd_addr)] = sd_wdata;
            if (sd_req && !sd_we)
            begin
                sq.push_back(sdm.exists(int'(sd_addr)) ? sdm[int'(sd_addr)] : 32'h0);
                st.push_back(cyc + 2);
            end
            out_ready <= sink_go && (!slow || cyc[1]);
            if (out_valid && out_ready)
                got.push_back(out_data);
        end
    end
endmodule : txf_far_model

// ==== tb/txf_top_tb.sv ====
// self-checking bench for the transmit queue block
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); end end
module txf_top_tb;
    import txf_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, mem_addr, mem_rdata, sd_wdata, sd_rdata, rd;
    logic        mem_req, mem_gnt, mem_rvalid, dma_req, chain_irq, sd_req, sd_we, sd_rvalid;
    logic [20:0] sd_addr;
    logic        out_valid, out_ready, slow, sink_go;
    logic [7:0]  out_data;
    logic [7:0]  exp_q [$];
    int          error_cnt, n_compared;
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    txf_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid),
        .mem_rdata(mem_rdata), .dma_req(dma_req), .chain_irq(chain_irq), .sd_req(sd_req), .sd_we(sd_we),
        .sd_addr(sd_addr), .sd_wdata(sd_wdata), .sd_rvalid(sd_rvalid), .sd_rdata(sd_rdata),
        .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));
    txf_far_model u_far (.pclk(pclk), .presetn(presetn), .slow(slow), .sink_go(sink_go),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid),
        .mem_rdata(mem_rdata), .sd_req(sd_req), .sd_we(sd_we), .sd_addr(sd_addr), .sd_wdata(sd_wdata),
        .sd_rvalid(sd_rvalid), .sd_rdata(sd_rdata), .out_valid(out_valid), .out_data(out_data),
        .out_ready(out_ready));
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (!pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        `CHK(nm, ex, rd)
    endtask : rd_chk
    // stream words leave low byte first
    task automatic push_exp(input logic [31:0] d);
        for (int i = 0; i < 4; i++)
            exp_q.push_back(d[8*i +: 8]);
    endtask : push_exp
    task automatic put_word(input logic [31:0] d);
        apb(1'b1, OFS_DATA, d);
        push_exp(d);
    endtask : put_word
    task automatic drain(input int n);
        logic [7:0] e;
        logic [7:0] g;
        repeat (4000) if (u_far.got.size() < n) @(posedge pclk);
        `CHK("byte count", n, u_far.got.size())
        while (u_far.got.size() > 0 && exp_q.size() > 0)
        begin
            // pop first: the compare macro names its arguments twice
            e = exp_q.pop_front();
            g = u_far.got.pop_front();
            `CHK("out byte", e, g)
        end
    endtask : drain
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    initial
    begin
        repeat (30000) @(posedge pclk);
        error_cnt++;
        test_done();
    end
    initial
    begin
        {presetn, psel, penable, pwrite, slow, sink_go} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        error_cnt = 0;
        n_compared = 0;
        // descriptors and buffers on four byte boundaries
        {u_far.hmem[16], u_far.hmem[17], u_far.hmem[18]} = {32'h80, 32'h8, 32'h50};
        // final descriptor carries the last flag
        {u_far.hmem[20], u_far.hmem[21], u_far.hmem[22]} = {32'hA0, 32'h4, 32'h61};
        {u_far.hmem[32], u_far.hmem[33], u_far.hmem[40]} = {32'h0403_0201, 32'h0807_0605, 32'h0C0B_0A09};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("fill", OFS_FILL, {8'h00, FILL_RST});
        rd_chk("load", OFS_LOAD, 32'h0);
        `CHK("dma_req", 1'b0, dma_req)
        apb(1'b1, 12'h01C, 32'h1);
        `CHK("slverr", 1'b1, err)
        apb(1'b1, OFS_FILL, 32'h8);
        apb(1'b1, OFS_CTRL, 32'h1);
        @(posedge pclk);
        `CHK("dma_req", 1'b1, dma_req)
        put_word(32'h4433_2211);
        put_word(32'h8877_6655);
        rd_chk("load", OFS_LOAD, 32'h8);
        @(posedge pclk);
        `CHK("dma_req", 1'b0, dma_req)
        apb(1'b1, OFS_FILL, 32'h9);
        @(posedge pclk);
        `CHK("dma_req", 1'b1, dma_req)
        sink_go <= 1'b1;
        drain(8);
        rd_chk("load", OFS_LOAD, 32'h0);
        slow <= 1'b1;
        push_exp(u_far.hmem[32]);
        push_exp(u_far.hmem[33]);
        apb(1'b1, OFS_FILL, {8'h00, FILL_RST});
        apb(1'b1, OFS_DESC, 32'h40);
        apb(1'b1, OFS_CTRL, 32'h7);
        // engine is moving the first segment, so this stream word waits and lands between segments
        repeat (3000) if (!(mem_req && mem_addr == 32'h80)) @(posedge pclk);
        put_word(32'hDDCC_BBAA);
        push_exp(u_far.hmem[40]);
        repeat (3000) if (!chain_irq) @(posedge pclk);
        `CHK("chain_irq", 1'b1, chain_irq)
        drain(16);
        rd_chk("irq", OFS_IRQ, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h1);
        @(posedge pclk);
        `CHK("chain_irq", 1'b0, chain_irq)
        apb(1'b1, OFS_CTRL, 32'h3);
        @(posedge pclk);
        `CHK("chain_irq", 1'b1, chain_irq)
        apb(1'b1, OFS_IRQ, 32'h1);
        @(posedge pclk);
        `CHK("chain_irq", 1'b0, chain_irq)
        rd_chk("load", OFS_LOAD, 32'h0);
        rd_chk("diag", OFS_DIAG, 32'h0000_0800);
        test_done();
    end
endmodule : txf_top_tb
